/* File: rtl/sof_top.sv */
// Safety output and shared fail line logic with register port
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
module sof_top (
	input  wire logic              I_CLK_SYS,
	input  wire logic              I_RESET_N,
	input  wire logic [3:0]        i_addr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	input  wire sof_pkg::sof_fault_t i_fault,
	input  wire sof_pkg::sof_power_t i_power,
	input  wire logic              i_active_safe_mode_fuse,
	input  wire logic              i_fail_line_enable_fuse,
	input  wire logic              i_secure_en,
	input  wire logic              i_input_undervoltage_detect,
	input  wire logic              i_shared_fail_line,
	output logic [7:0]             o_rdata,
	output logic                   o_safe_state_out_oe_n,
	output logic                   o_shared_fail_line_oe_n,
	output logic                   o_power_down_start,
	output logic                   o_powerup_go,
	output logic                   o_reload_fuses
);

	localparam logic [11:0] WARN_N = 12'(sof_pkg::WARN_LEAD_CYC);
	localparam logic [11:0] REL_N  = 12'(sof_pkg::REL_DELAY_CYC);
	localparam logic [11:0] DEB_N  = 12'(sof_pkg::DEBOUNCE_CYC);

	logic [7:0]  ctrl_r;
	logic [4:0]  flags_r;
	logic [4:0]  pend_clr_r;
	logic [7:0]  chal_r;
	logic [7:0]  lfsr_r;
	logic        chal_armed_r;
	logic        safe_low_r;
	logic        line_s1_r;
	logic        line_s2_r;
	logic [11:0] deb_cnt_r;
	logic [11:0] tmr_r;
	logic        hard_wd_r;
	logic        fail_low_r;
	logic        pdown_r;
	logic        go_r;
	logic        reload_r;
	logic [7:0]  rdata_r;
	logic        active_mode;
	logic        hard_fault;
	logic        wdi_cause;
	logic [4:0]  set_v;
	logic [4:0]  clr_v;
	logic        forced;
	logic        exit_ok;
	logic        ext_low;
	logic        internal_fault;
	logic        wr_ctrl;
	logic        wr_flags;
	logic        wr_resp;
	sof_pkg::sof_fail_st_t st_r;

	// Variant without the fuse is tied low at the pin, giving fault mode
	assign active_mode = i_active_safe_mode_fuse;

	// Hard fault shutdown sources
	assign hard_fault = i_fault.fault_timer | i_fault.regulator_fault_counter_max
		| i_fault.wd_cnt_max | i_fault.pwrup_fail
		| i_fault.thermal_sd;

	// Soft watchdog input resets use the WDI enable; hard ones (wdi_hard) are not gated
	assign wdi_cause = i_fault.wdi_event & ctrl_r[sof_pkg::BIT_WDI];

	// Per-cause flag sets gated by enables, except the active-mode latch
	always_comb begin
		set_v = '0;
		set_v[sof_pkg::BIT_REG]  = i_fault.reg_fault
			& ctrl_r[sof_pkg::BIT_REG];
		set_v[sof_pkg::BIT_WDI]  = wdi_cause;
		set_v[sof_pkg::BIT_WDC]  = i_fault.wdc_event
			& ctrl_r[sof_pkg::BIT_WDC];
		set_v[sof_pkg::BIT_HARD] = hard_fault
			& ctrl_r[sof_pkg::BIT_HARD];
		// Entry only: the latched flag must not keep setting itself
		set_v[sof_pkg::BIT_ASS]  = active_mode & forced
			& ~flags_r[sof_pkg::BIT_ASS];
	end

	// Active-mode forcing conditions
	assign forced = i_power.self_test_flag | i_fault.wdi_hard
		| flags_r[sof_pkg::BIT_WDI] | flags_r[sof_pkg::BIT_REG]
		| (i_power.off_mode & i_power.host_reset_low)
		| flags_r[sof_pkg::BIT_ASS];

	assign exit_ok = ~i_power.host_reset_low & ~i_power.self_test_flag
		& ~i_fault.reg_fault & (flags_r == '0);

	// Register strobes
	assign wr_ctrl  = i_wr & (i_addr == sof_pkg::ADDR_CTRL);
	assign wr_flags = i_wr & (i_addr == sof_pkg::ADDR_FLAGS);
	assign wr_resp  = i_wr & (i_addr == sof_pkg::ADDR_RESP);

	// Clear mask applies now or after a matching response
	always_comb begin
		clr_v = '0;
		if (wr_flags && !(active_mode && i_secure_en))
			clr_v = i_wdata[4:0];
		else if (wr_resp && chal_armed_r && i_wdata == chal_r)
			clr_v = pend_clr_r;
	end

	// Enable register
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N)
			ctrl_r <= sof_pkg::CTRL_RST;
		else if (wr_ctrl)
			ctrl_r <= i_wdata;
	end

	// Sticky flags, a set beats a clear in the same cycle
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N)
			flags_r <= '0;
		else
			flags_r <= (flags_r & ~clr_v) | set_v;
	end

	// Challenge generator runs freely
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N)
			lfsr_r <= sof_pkg::CHAL_SEED;
		else
			lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5]
				^ lfsr_r[4] ^ lfsr_r[3]};
	end

	// Secure clear: flag write arms a challenge, any response ends it
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N) begin
			chal_armed_r <= 1'b0;
			chal_r       <= '0;
			pend_clr_r   <= '0;
		end else if (wr_flags && active_mode && i_secure_en) begin
			chal_armed_r <= 1'b1;
			chal_r       <= lfsr_r;
			pend_clr_r   <= i_wdata[4:0];
		end else if (wr_resp || wr_ctrl) begin
			chal_armed_r <= 1'b0;
			chal_r       <= '0;
			pend_clr_r   <= '0;
		end
	end

	// Safe-state output, low means the pin is pulled down
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N)
			safe_low_r <= 1'b0;
		else if (active_mode) begin
			if (i_power.fuses_loaded && !exit_ok)
				safe_low_r <= 1'b1;
			else if (exit_ok)
				safe_low_r <= 1'b0;
		end else if (i_input_undervoltage_detect)
			safe_low_r <= 1'b0;
		else if (set_v != '0)
			safe_low_r <= 1'b1;
		else if (flags_r == '0)
			safe_low_r <= 1'b0;
	end

	// Fail line pin synchroniser
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N) begin
			line_s1_r <= 1'b1;
			line_s2_r <= 1'b1;
		end else begin
			line_s1_r <= i_shared_fail_line;
			line_s2_r <= line_s1_r;
		end
	end

	// Others pulling low only counts while we release the line
	assign ext_low = ~line_s2_r & ~fail_low_r;
	assign internal_fault = hard_fault | i_fault.wdi_hard;

	// Debounce of an external low in system-on
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N)
			deb_cnt_r <= '0;
		else if (!(ext_low && i_power.system_on && i_fail_line_enable_fuse
			&& st_r == sof_pkg::FS_ON))
			deb_cnt_r <= '0;
		else if (deb_cnt_r != DEB_N)
			deb_cnt_r <= deb_cnt_r + 12'h001;
	end

	// Fail line sequencer
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N) begin
			st_r       <= sof_pkg::FS_OFF;
			tmr_r      <= '0;
			hard_wd_r  <= 1'b0;
			fail_low_r <= 1'b0;
			pdown_r    <= 1'b0;
			go_r       <= 1'b0;
			reload_r   <= 1'b0;
		end else begin
			pdown_r  <= 1'b0;
			reload_r <= 1'b0;
			unique case (st_r)
			sof_pkg::FS_OFF: begin
				fail_low_r <= i_fail_line_enable_fuse;
				go_r       <= 1'b0;
				if (i_power.power_on_request_ready) begin
					fail_low_r <= 1'b0;
					st_r       <= sof_pkg::FS_WAIT_HIGH;
				end
			end
			sof_pkg::FS_WAIT_HIGH: begin
				if (line_s2_r || !i_fail_line_enable_fuse) begin
					go_r <= 1'b1;
					st_r <= sof_pkg::FS_ON;
				end
			end
			sof_pkg::FS_ON: begin
				tmr_r <= '0;
				if (!i_fail_line_enable_fuse) begin
					if (internal_fault)
						pdown_r <= 1'b1;
					if (i_power.off_mode)
						st_r <= sof_pkg::FS_OFF;
				end else if (internal_fault) begin
					fail_low_r <= 1'b1;
					hard_wd_r  <= i_fault.wdi_hard;
					st_r       <= sof_pkg::FS_WARN;
				end else if (deb_cnt_r == DEB_N) begin
					fail_low_r <= 1'b1;
					pdown_r    <= 1'b1;
					st_r       <= sof_pkg::FS_DOWN;
				end else if (i_power.off_mode) begin
					st_r <= sof_pkg::FS_OFF;
				end
			end
			sof_pkg::FS_WARN: begin
				tmr_r <= tmr_r + 12'h001;
				if (tmr_r == WARN_N - 12'h001) begin
					pdown_r <= 1'b1;
					tmr_r   <= '0;
					st_r    <= sof_pkg::FS_DOWN;
				end
			end
			sof_pkg::FS_DOWN: begin
				if (!i_power.outputs_off)
					tmr_r <= '0;
				else if (hard_wd_r)
					st_r <= sof_pkg::FS_RELDLY;
				else
					st_r <= sof_pkg::FS_OFF;
				go_r <= 1'b0;
			end
			sof_pkg::FS_RELDLY: begin
				tmr_r <= i_power.outputs_off ? tmr_r + 12'h001 : '0;
				if (tmr_r == REL_N - 12'h001) begin
					fail_low_r <= 1'b0;
					reload_r   <= 1'b1;
					hard_wd_r  <= 1'b0;
					st_r       <= sof_pkg::FS_WAIT_HIGH;
				end
			end
			default: st_r <= sof_pkg::FS_OFF;
			endcase
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N)
			rdata_r <= '0;
		else if (!i_rd)
			rdata_r <= '0;
		else begin
			unique case (i_addr)
			sof_pkg::ADDR_CTRL:   rdata_r <= ctrl_r;
			sof_pkg::ADDR_FLAGS:  rdata_r <= {3'h0, flags_r};
			sof_pkg::ADDR_STATUS: rdata_r <= {5'h0, fail_low_r,
				~line_s2_r, safe_low_r};
			sof_pkg::ADDR_CHAL:   rdata_r <= chal_r;
			default:              rdata_r <= '0;
			endcase
		end
	end

	// Output enables are active low: low drives the pin
	assign o_rdata                 = rdata_r;
	assign o_safe_state_out_oe_n   = ~safe_low_r;
	assign o_shared_fail_line_oe_n = ~fail_low_r;
	assign o_power_down_start      = pdown_r;
	assign o_powerup_go            = go_r;
	assign o_reload_fuses          = reload_r;

	// Checks beside the logic
	property p_sticky_reg;
		@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		set_v[sof_pkg::BIT_REG] |=> flags_r[sof_pkg::BIT_REG];
	endproperty
	a_sticky_reg: assert property (p_sticky_reg)
		else $error("regulator flag not set");

	property p_fault_assert;
		@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		(!active_mode && set_v != '0 && !i_input_undervoltage_detect)
		|=> !o_safe_state_out_oe_n;
	endproperty
	a_fault_assert: assert property (p_fault_assert)
		else $error("safe output not asserted on cause");

	property p_uv_release;
		@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		(!active_mode && i_input_undervoltage_detect)
		|=> o_safe_state_out_oe_n;
	endproperty
	a_uv_release: assert property (p_uv_release)
		else $error("safe output held in undervoltage");

	property p_active_exit;
		@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		(active_mode && !exit_ok && i_power.fuses_loaded)
		|=> !o_safe_state_out_oe_n;
	endproperty
	a_active_exit: assert property (p_active_exit)
		else $error("active mode released early");

	property p_latch_flag;
		@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		(active_mode && forced && !(flags_r[sof_pkg::BIT_ASS]
			&& clr_v[sof_pkg::BIT_ASS])) |=> flags_r[sof_pkg::BIT_ASS];
	endproperty
	a_latch_flag: assert property (p_latch_flag)
		else $error("latched flag missing");

	sequence s_warn_start;
		st_r == sof_pkg::FS_ON && i_fail_line_enable_fuse && internal_fault;
	endsequence
	property p_warn_lead;
		@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		s_warn_start |=> !o_shared_fail_line_oe_n;
	endproperty
	a_warn_lead: assert property (p_warn_lead)
		else $error("fail line not pulled on warning");

	// Own count of warning cycles, apart from the sequencer's timer
	logic [11:0] warn_cyc_r;
	always_ff @(posedge I_CLK_SYS)
		warn_cyc_r <= (st_r == sof_pkg::FS_WARN)
			? warn_cyc_r + 12'h001 : '0;
	property p_warn_done;
		@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		(st_r == sof_pkg::FS_WARN && warn_cyc_r == WARN_N - 12'h001)
		|=> o_power_down_start;
	endproperty
	a_warn_done: assert property (p_warn_done)
		else $error("power-down not after lead");

	property p_off_low;
		@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		(st_r == sof_pkg::FS_OFF && i_fail_line_enable_fuse
			&& !i_power.power_on_request_ready) |=> !o_shared_fail_line_oe_n;
	endproperty
	a_off_low: assert property (p_off_low)
		else $error("fail line not low in off");

	property p_ignore_line;
		@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		!i_fail_line_enable_fuse |-> deb_cnt_r != DEB_N
			|| st_r != sof_pkg::FS_ON;
	endproperty
	a_ignore_line: assert property (p_ignore_line)
		else $error("line acted on while disabled");

	property p_pause;
		@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		(st_r == sof_pkg::FS_WAIT_HIGH && !line_s2_r
			&& i_fail_line_enable_fuse) |=> !o_powerup_go;
	endproperty
	a_pause: assert property (p_pause)
		else $error("power-up not paused");

endmodule : sof_top

/* File: rtl/sof_pkg.sv */
// Package for the safety output and shared fail line block
package sof_pkg;

	// Clock rate and interval figures
	localparam int CLK_MHZ         = 100;
	localparam int WARN_LEAD_US    = 20;
	localparam int REL_DELAY_US    = 30;
	localparam int DEBOUNCE_US     = 20;
	localparam int WARN_LEAD_CYC   = WARN_LEAD_US * CLK_MHZ;
	localparam int REL_DELAY_CYC   = REL_DELAY_US * CLK_MHZ;
	localparam int DEBOUNCE_CYC    = DEBOUNCE_US * CLK_MHZ;
	localparam int CNT_W           = 12;

	// Register indices on the plain register port
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_FLAGS  = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_CHAL   = 4'h3;
	localparam logic [3:0] ADDR_RESP   = 4'h4;

	// Field positions in the enable and flag registers
	localparam int BIT_REG  = 0;
	localparam int BIT_WDI  = 1;
	localparam int BIT_WDC  = 2;
	localparam int BIT_HARD = 3;
	localparam int BIT_ASS  = 4;
	localparam int BIT_SEC  = 5;

	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] CHAL_SEED = 8'h5A;

	// Fault inputs from the rest of the device
	typedef struct packed {
		logic reg_fault;
		logic wdi_event;
		logic wdi_hard;
		logic wdc_event;
		logic fault_timer;
		logic regulator_fault_counter_max;
		logic wd_cnt_max;
		logic pwrup_fail;
		logic thermal_sd;
	} sof_fault_t;

	// Power state inputs from the sequencer
	typedef struct packed {
		logic off_mode;
		logic system_on;
		logic power_on_request_ready;
		logic outputs_off;
		logic host_reset_low;
		logic self_test_flag;
		logic fuses_loaded;
	} sof_power_t;

	typedef enum logic [2:0] {
		FS_OFF, FS_WAIT_HIGH, FS_ON, FS_WARN, FS_DOWN, FS_RELDLY
	} sof_fail_st_t;

endpackage : sof_pkg

/* File: bench/sof_peer.sv */
// Companion device on the shared fail line, with the line's pull-up
module sof_peer (
	input  wire logic i_dut_oe_n,
	input  wire logic i_hold,
	output logic      o_line
);
	timeunit 1ns;
	timeprecision 1ns;

	// Open drain: any party pulling wins, else the pull-up lifts the line
	assign o_line = i_dut_oe_n & ~i_hold;
endmodule : sof_peer

/* File: bench/sof_top_bench.sv */
// Self-checking bench for the safety output and fail line block
module sof_top_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic                clk      = 1'b0;
	logic                rst_n    = 1'b0;
	logic [3:0]          addr     = 4'h0;
	logic [7:0]          wdata    = 8'h00;
	logic                wr       = 1'b0;
	logic                rd       = 1'b0;
	sof_pkg::sof_fault_t flt      = '0;
	sof_pkg::sof_power_t pwr      = '0;
	logic                ass_fuse = 1'b0;
	logic                fl_fuse  = 1'b0;
	logic                sec      = 1'b0;
	logic                uv       = 1'b0;
	logic                hold     = 1'b0;
	logic                line;
	logic                ss_oe_n;
	logic                fl_oe_n;
	logic                pds;
	logic                pgo;
	logic                reload;
	logic [7:0]          rdata;
	logic [7:0]          d;
	int                  num_errors  = 0;
	int                  comparisons = 0;
	int                  n;
	// Fault field per cause and the flag bit it should set
	int                  fb[8] = '{8, 7, 5, 4, 3, 2, 1, 0};
	int                  eb[8] = '{0, 1, 2, 3, 3, 3, 3, 3};

	// Free-running system clock
	always #5 clk = ~clk;

	sof_top dut_u (
		.I_CLK_SYS                   (clk),
		.I_RESET_N                   (rst_n),
		.i_addr                      (addr),
		.i_wdata                     (wdata),
		.i_wr                        (wr),
		.i_rd                        (rd),
		.i_fault                     (flt),
		.i_power                     (pwr),
		.i_active_safe_mode_fuse     (ass_fuse),
		.i_fail_line_enable_fuse     (fl_fuse),
		.i_secure_en                 (sec),
		.i_input_undervoltage_detect (uv),
		.i_shared_fail_line          (line),
		.o_rdata                     (rdata),
		.o_safe_state_out_oe_n       (ss_oe_n),
		.o_shared_fail_line_oe_n     (fl_oe_n),
		.o_power_down_start          (pds),
		.o_powerup_go                (pgo),
		.o_reload_fuses              (reload)
	);

	sof_peer peer_u (
		.i_dut_oe_n (fl_oe_n),
		.i_hold     (hold),
		.o_line     (line)
	);

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// Let k edges pass, then settle past the last one
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		cyc(1);
	endtask : do_reset

	task automatic pulse(input sof_pkg::sof_fault_t f);
		@(posedge clk);
		flt <= f;
		@(posedge clk);
		flt <= '0;
		cyc(4);
	endtask : pulse

	function automatic logic pick(input int sel);
		case (sel)
			0:       pick = pds;
			1:       pick = pgo;
			default: pick = reload;
		endcase
	endfunction : pick

	// Bounded wait; n ends as the number of cycles waited
	task automatic wait_for(input int sel, input int lim);
		n = 0;
		while (pick(sel) !== 1'b1) begin
			cyc(1);
			n++;
			if (n > lim) begin
				num_errors++;
				$display("ERROR %0t: wait ran out", $time);
				conclude();
			end
		end
	endtask : wait_for

	// Counts power-down pulses over k cycles; a spurious pulse is the hazard
	task automatic count_pds(input int k);
		n = 0;
		repeat (k) begin
			cyc(1);
			if (pds === 1'b1) n++;
		end
	endtask : count_pds

	// Off, then power-on with the peer late to release the line
	task automatic power_up();
		@(posedge clk);
		pwr.off_mode    <= 1'b1;
		pwr.system_on   <= 1'b0;
		pwr.outputs_off <= 1'b1;
		cyc(4);
		check(fl_oe_n, 1'b0);
		@(posedge clk);
		pwr.power_on_request_ready <= 1'b1;
		pwr.off_mode    <= 1'b0;
		pwr.outputs_off <= 1'b0;
		hold            <= 1'b1;
		cyc(50);
		check(pgo, 1'b0);
		@(posedge clk);
		hold <= 1'b0;
		wait_for(1, 40);
		check(fl_oe_n, 1'b1);
		@(posedge clk);
		pwr.off_mode    <= 1'b0;
		pwr.system_on   <= 1'b1;
		pwr.power_on_request_ready <= 1'b0;
		cyc(4);
	endtask : power_up

	initial begin
		pwr.fuses_loaded = 1'b1;
		do_reset();
		check(ss_oe_n, 1'b1);
		rd_reg(sof_pkg::ADDR_CTRL, d);
		check(d, sof_pkg::CTRL_RST);
		rd_reg(4'h7, d);
		check(d, 8'h00);
		$display("test reset done");

		// Each cause: ignored while disabled, latched while enabled
		for (int i = 0; i < 8; i++) begin
			wr_reg(sof_pkg::ADDR_CTRL, 8'h00);
			pulse(sof_pkg::sof_fault_t'(9'h001 << fb[i]));
			check(ss_oe_n, 1'b1);
			wr_reg(sof_pkg::ADDR_CTRL, 8'h0F);
			pulse(sof_pkg::sof_fault_t'(9'h001 << fb[i]));
			check(ss_oe_n, 1'b0);
			rd_reg(sof_pkg::ADDR_FLAGS, d);
			check(d, 8'h01 << eb[i]);
			wr_reg(sof_pkg::ADDR_FLAGS, 8'h1F);
			cyc(3);
			check(ss_oe_n, 1'b1);
		end
		pulse(sof_pkg::sof_fault_t'(9'h001));
		rd_reg(sof_pkg::ADDR_STATUS, d);
		check(d, 8'h01);
		@(posedge clk);
		uv <= 1'b1;
		cyc(3);
		check(ss_oe_n, 1'b1);
		@(posedge clk);
		uv <= 1'b0;
		wr_reg(sof_pkg::ADDR_FLAGS, 8'h1F);
		@(posedge clk);
		hold <= 1'b1;
		count_pds(2100);
		check(n, 0);
		check(fl_oe_n, 1'b1);
		@(posedge clk);
		hold <= 1'b0;
		$display("test fault mode done");

		// Internal fault warns on the line before power-down
		@(posedge clk);
		fl_fuse <= 1'b1;
		power_up();
		pulse(sof_pkg::sof_fault_t'(9'h001));
		check(fl_oe_n, 1'b0);
		wait_for(0, sof_pkg::WARN_LEAD_CYC + 10);
		check(n >= sof_pkg::WARN_LEAD_CYC - 8, 1'b1);
		check(n <= sof_pkg::WARN_LEAD_CYC + 2, 1'b1);

		// External low: a short glitch, then a full debounce
		power_up();
		@(posedge clk);
		hold <= 1'b1;
		count_pds(1500);
		check(n, 0);
		@(posedge clk);
		hold <= 1'b0;
		cyc(5);
		@(posedge clk);
		hold <= 1'b1;
		wait_for(0, sof_pkg::DEBOUNCE_CYC + 10);
		check(n >= sof_pkg::DEBOUNCE_CYC, 1'b1);
		check(n <= sof_pkg::DEBOUNCE_CYC + 6, 1'b1);
		check(fl_oe_n, 1'b0);
		@(posedge clk);
		hold <= 1'b0;

		// Hard watchdog: warn, power down, release after the delay
		power_up();
		pulse(sof_pkg::sof_fault_t'(9'h040));
		check(fl_oe_n, 1'b0);
		wait_for(0, sof_pkg::WARN_LEAD_CYC + 10);
		check(n >= sof_pkg::WARN_LEAD_CYC - 8, 1'b1);
		@(posedge clk);
		pwr.outputs_off <= 1'b1;
		wait_for(2, sof_pkg::REL_DELAY_CYC + 10);
		check(n >= sof_pkg::REL_DELAY_CYC, 1'b1);
		check(n <= sof_pkg::REL_DELAY_CYC + 4, 1'b1);
		cyc(1);
		check(fl_oe_n, 1'b1);
		$display("test fail line done");

		// Active mode from fuse load, held while the host is in reset
		@(posedge clk);
		fl_fuse             <= 1'b0;
		ass_fuse            <= 1'b1;
		pwr.host_reset_low  <= 1'b1;
		pwr.off_mode        <= 1'b1;
		do_reset();
		cyc(2);
		check(ss_oe_n, 1'b0);
		rd_reg(sof_pkg::ADDR_FLAGS, d);
		check(d, 8'h10);
		@(posedge clk);
		pwr.host_reset_low <= 1'b0;
		pwr.off_mode       <= 1'b0;
		wr_reg(sof_pkg::ADDR_FLAGS, 8'h1F);
		cyc(3);
		check(ss_oe_n, 1'b1);

		// Secure clear: a wrong response keeps the flags
		@(posedge clk);
		sec <= 1'b1;
		wr_reg(sof_pkg::ADDR_CTRL, 8'h01);
		pulse(sof_pkg::sof_fault_t'(9'h100));
		check(ss_oe_n, 1'b0);
		wr_reg(sof_pkg::ADDR_FLAGS, 8'h1F);
		rd_reg(sof_pkg::ADDR_CHAL, d);
		wr_reg(sof_pkg::ADDR_RESP, ~d);
		rd_reg(sof_pkg::ADDR_FLAGS, d);
		check(d, 8'h11);
		wr_reg(sof_pkg::ADDR_FLAGS, 8'h1F);
		rd_reg(sof_pkg::ADDR_CHAL, d);
		wr_reg(sof_pkg::ADDR_RESP, d);
		rd_reg(sof_pkg::ADDR_FLAGS, d);
		check(d, 8'h00);
		cyc(2);
		check(ss_oe_n, 1'b1);
		$display("test active mode done");
		conclude();
	end
endmodule : sof_top_bench
